/* logic/gpio_bank_pkg.sv */
// shared constants, register map and field layout of the pin bank
package gpio_bank_pkg;
	localparam int GP_LINES = 10;
	localparam int GP_LO = 2;
	localparam int AN_LINES = 2;
	localparam int ADDR_W = 8;
	// register byte offsets
	localparam logic [7:0] OFS_GP_DIR = 8'h00;
	localparam logic [7:0] OFS_GP_OUT = 8'h04;
	localparam logic [7:0] OFS_GP_IN = 8'h08;
	localparam logic [7:0] OFS_GP_PULL = 8'h0c;
	localparam logic [7:0] OFS_AN_CTRL = 8'h10;
	localparam logic [7:0] OFS_AN_IN = 8'h14;
	localparam logic [7:0] OFS_COEX = 8'h18;
	localparam logic [7:0] OFS_COEX_STAT = 8'h1c;
	// pull codes, two bits per line
	localparam logic [1:0] PULL_WEAK_DN = 2'h0;
	localparam logic [1:0] PULL_STRONG_DN = 2'h1;
	localparam logic [1:0] PULL_WEAK_UP = 2'h2;
	localparam logic [1:0] PULL_STRONG_UP = 2'h3;
	// coexistence control bits
	localparam int COEX_PRIO_EN = 0;
	localparam int COEX_BUSY_EN = 1;
	localparam int COEX_PEER_EN = 2;
	localparam int COEX_PRIO_VAL = 3;
	localparam int COEX_BUSY_VAL = 4;
	// analog control: dir in [1:0], out in [9:8]
	localparam int AN_OUT_POS = 8;
	// reset values, decode-error read data and response codes
	localparam logic [9:0] GP_DIR_RST = 10'h000;
	localparam logic [19:0] GP_PULL_RST = 20'h00000;
	localparam logic [31:0] DECERR_DATA = 32'h00000000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [9:0] dir;
		logic [9:0] dout;
		logic [19:0] pull;
		logic [1:0] an_dir;
		logic [1:0] an_out;
		logic [4:0] coex;
	} cfg_t;
	typedef struct packed {
		logic [9:0] oe;
		logic [9:0] o;
		logic [9:0] pu_weak;
		logic [9:0] pu_strong;
		logic [9:0] pd_weak;
		logic [9:0] pd_strong;
	} gp_pins_t;
endpackage

/* logic/gpio_pad_ctrl.sv */
// per-line pad drive and termination decoding for the general-purpose lines
`timescale 1ns/10ps
module gpio_pad_ctrl (
	input wire logic clock_i,
	input wire logic in_rst_i,
	input wire gpio_bank_pkg::cfg_t cfg_i,
	output gpio_bank_pkg::gp_pins_t pins_o
);
	gpio_bank_pkg::gp_pins_t st_q;
	gpio_bank_pkg::gp_pins_t st_d;

	// map pull code of one line onto its four termination enables
	function automatic logic [3:0] pull_dec(input logic [1:0] code);
		logic [3:0] r;
		r = 4'h0;
		case (code)
			gpio_bank_pkg::PULL_WEAK_DN: r = 4'h1;
			gpio_bank_pkg::PULL_STRONG_DN: r = 4'h2;
			gpio_bank_pkg::PULL_WEAK_UP: r = 4'h4;
			gpio_bank_pkg::PULL_STRONG_UP: r = 4'h8;
			default: r = 4'h1;
		endcase
		return r;
	endfunction

	// lines 2,3 driven by coexistence override when enabled
	always_comb
	begin
		logic [3:0] t;
		t = 4'h0;
		st_d = '0;
		for (int i = 0; i < gpio_bank_pkg::GP_LINES; i++)
		begin
			t = pull_dec(cfg_i.pull[2*i +: 2]);
			st_d.pd_weak[i] = t[0];
			st_d.pd_strong[i] = t[1];
			st_d.pu_weak[i] = t[2];
			st_d.pu_strong[i] = t[3];
			st_d.oe[i] = cfg_i.dir[i];
			st_d.o[i] = cfg_i.dout[i];
		end
		if (cfg_i.coex[gpio_bank_pkg::COEX_PRIO_EN])
		begin
			st_d.oe[2] = 1'b1;
			st_d.o[2] = cfg_i.coex[gpio_bank_pkg::COEX_PRIO_VAL];
		end
		if (cfg_i.coex[gpio_bank_pkg::COEX_BUSY_EN])
		begin
			st_d.oe[3] = 1'b1;
			st_d.o[3] = cfg_i.coex[gpio_bank_pkg::COEX_BUSY_VAL];
		end
		// peer input line never drives while it serves coexistence
		if (cfg_i.coex[gpio_bank_pkg::COEX_PEER_EN])
			st_d.oe[4] = 1'b0;
		if (in_rst_i)
		begin
			st_d.oe = '0;
			st_d.pd_weak = '1;
			st_d.pd_strong = '0;
			st_d.pu_weak = '0;
			st_d.pu_strong = '0;
		end
	end

	always_ff @(posedge clock_i)
		st_q <= st_d;

	assign pins_o = st_q;
endmodule

/* logic/gpio_bank.sv */
// general-purpose pin bank with coexistence roles and an axi4-lite register port
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
module gpio_bank (
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic module_rst_n_i,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [9:0] gp_line_i,
	output logic [9:0] gp_line_o,
	output logic [9:0] gp_line_oe_o,
	output logic [9:0] gp_pull_up_weak_o,
	output logic [9:0] gp_pull_up_strong_o,
	output logic [9:0] gp_pull_dn_weak_o,
	output logic [9:0] gp_pull_dn_strong_o,
	input wire logic [1:0] analog_capable_line_i,
	output logic [1:0] analog_capable_line_o,
	output logic [1:0] analog_capable_line_oe_o,
	output logic coexist_peer_busy_o
);
	typedef struct packed {
		gpio_bank_pkg::cfg_t cfg;
		logic [7:0] awaddr;
		logic aw_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic w_have;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [9:0] gp_smp;
		logic [1:0] an_smp;
		logic in_rst;
	} state_t;

	state_t st_q;
	state_t st_d;
	gpio_bank_pkg::gp_pins_t pins;
	gpio_bank_pkg::cfg_t reset_cfg;

	assign reset_cfg = '{dir: gpio_bank_pkg::GP_DIR_RST, dout: '0,
		pull: gpio_bank_pkg::GP_PULL_RST, an_dir: '0, an_out: '0, coex: '0};

	// true when the word offset names a mapped register
	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= gpio_bank_pkg::OFS_COEX_STAT;
	endfunction

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	// register read view, unused upper bits read as zero
	function automatic logic [31:0] rd_word(input state_t s, input logic [7:0] a);
		logic [31:0] r;
		r = gpio_bank_pkg::DECERR_DATA;
		case (a)
			gpio_bank_pkg::OFS_GP_DIR: r = {22'h0, s.cfg.dir};
			gpio_bank_pkg::OFS_GP_OUT: r = {22'h0, s.cfg.dout};
			gpio_bank_pkg::OFS_GP_IN: r = {22'h0, s.gp_smp};
			gpio_bank_pkg::OFS_GP_PULL: r = {12'h0, s.cfg.pull};
			gpio_bank_pkg::OFS_AN_CTRL: r = {22'h0, s.cfg.an_out, 6'h0, s.cfg.an_dir};
			gpio_bank_pkg::OFS_AN_IN: r = {30'h0, s.an_smp};
			gpio_bank_pkg::OFS_COEX: r = {27'h0, s.cfg.coex};
			gpio_bank_pkg::OFS_COEX_STAT: r = {31'h0, s.gp_smp[4]};
			default: r = gpio_bank_pkg::DECERR_DATA;
		endcase
		return r;
	endfunction

	always_comb
	begin
		logic [31:0] w;
		w = '0;
		st_d = st_q;
		st_d.in_rst = ~module_rst_n_i;
		st_d.gp_smp = gp_line_i;
		st_d.an_smp = analog_capable_line_i;
		// write path: address and data accepted in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			st_d.aw_have = 1'b1;
			st_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			st_d.w_have = 1'b1;
			st_d.wdata = s_axi_wdata;
			st_d.wstrb = s_axi_wstrb;
		end
		if (st_q.aw_have && st_q.w_have && !st_q.bvalid)
		begin
			st_d.aw_have = 1'b0;
			st_d.w_have = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = mapped(st_q.awaddr) ? gpio_bank_pkg::RESP_OKAY
				: gpio_bank_pkg::RESP_SLVERR;
			w = merge(rd_word(st_q, st_q.awaddr), st_q.wdata, st_q.wstrb);
			case (st_q.awaddr)
				gpio_bank_pkg::OFS_GP_DIR: st_d.cfg.dir = w[9:0];
				gpio_bank_pkg::OFS_GP_OUT: st_d.cfg.dout = w[9:0];
				gpio_bank_pkg::OFS_GP_PULL: st_d.cfg.pull = w[19:0];
				gpio_bank_pkg::OFS_AN_CTRL:
				begin
					st_d.cfg.an_dir = w[1:0];
					st_d.cfg.an_out = w[gpio_bank_pkg::AN_OUT_POS +: 2];
				end
				gpio_bank_pkg::OFS_COEX: st_d.cfg.coex = w[4:0];
				default: st_d.cfg = st_q.cfg;
			endcase
		end
		if (st_q.bvalid && s_axi_bready)
			st_d.bvalid = 1'b0;
		// read path: one read under way at a time
		if (s_axi_arvalid && s_axi_arready)
		begin
			st_d.rvalid = 1'b1;
			st_d.rdata = rd_word(st_q, s_axi_araddr);
			st_d.rresp = mapped(s_axi_araddr) ? gpio_bank_pkg::RESP_OKAY
				: gpio_bank_pkg::RESP_SLVERR;
		end
		else if (st_q.rvalid && s_axi_rready)
			st_d.rvalid = 1'b0;
		// module reset pin returns configuration to its power-on state
		if (st_q.in_rst)
			st_d.cfg = reset_cfg;
	end

	// bus reset clears everything except in_rst, which it sets; pin reset handled above
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			st_q <= '0;
			st_q.in_rst <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	gpio_pad_ctrl u_pad (
		.clock_i(clock_i),
		.in_rst_i(st_q.in_rst || sys_rst_i),
		.cfg_i(st_q.cfg),
		.pins_o(pins)
	);

	// handshakes combinational, data from flip-flops
	assign s_axi_awready = !st_q.aw_have;
	assign s_axi_wready = !st_q.w_have;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = !st_q.rvalid;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign gp_line_o = pins.o;
	assign gp_line_oe_o = pins.oe;
	assign gp_pull_up_weak_o = pins.pu_weak;
	assign gp_pull_up_strong_o = pins.pu_strong;
	assign gp_pull_dn_weak_o = pins.pd_weak;
	assign gp_pull_dn_strong_o = pins.pd_strong;
	// analog lines held floating in reset
	assign analog_capable_line_o = st_q.cfg.an_out;
	assign analog_capable_line_oe_o = st_q.in_rst ? 2'h0 : st_q.cfg.an_dir;
	// peer busy only forwarded while line 4 serves coexistence
	assign coexist_peer_busy_o = st_q.cfg.coex[gpio_bank_pkg::COEX_PEER_EN]
		& st_q.gp_smp[4];

	AST_RST_FLOATS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!module_rst_n_i |-> ##2 (gp_line_oe_o == '0 && analog_capable_line_oe_o == '0))
		else $error("pins driven during module reset");
	AST_RST_PULLDN: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!module_rst_n_i |-> ##2 (gp_pull_dn_weak_o == '1 && gp_pull_up_weak_o == '0))
		else $error("weak pull-down missing in reset");
	AST_RST_ACTLOW: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!module_rst_n_i ##1 !module_rst_n_i |-> ##1 (st_q.cfg.dir == '0))
		else $error("config survives active-low reset");
	AST_OUT_FOLLOWS: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(st_q.cfg.coex[1:0] == 2'h0 && !st_q.in_rst) |-> ##1 (gp_line_o == $past(st_q.cfg.dout)))
		else $error("output does not follow written value");
	AST_IN_SAMPLE: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		1'b1 |-> ##1 (st_q.gp_smp == $past(gp_line_i)))
		else $error("sampled input stale");
	AST_PRIO_OUT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(st_q.cfg.coex[0] && !st_q.in_rst)
		|-> ##1 (gp_line_oe_o[2] && gp_line_o[2] == $past(st_q.cfg.coex[3])))
		else $error("priority line not driving");
	AST_BUSY_OUT: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(st_q.cfg.coex[1] && !st_q.in_rst)
		|-> ##1 (gp_line_oe_o[3] && gp_line_o[3] == $past(st_q.cfg.coex[4])))
		else $error("busy line wrong");
	AST_PEER_IN: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		st_q.cfg.coex[2] |-> ##1 !gp_line_oe_o[4])
		else $error("peer input line driving");
	AST_AN_RD: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == gpio_bank_pkg::OFS_AN_IN)
		|=> (s_axi_rvalid && s_axi_rdata[1:0] == $past(st_q.an_smp)))
		else $error("analog line read wrong");
	AST_PULL_SEL: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(!st_q.in_rst && st_q.cfg.pull[1:0] == gpio_bank_pkg::PULL_STRONG_UP)
		|-> ##1 gp_pull_up_strong_o[0])
		else $error("strong pull-up not applied");
	AST_DIR_WR: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		(!st_q.in_rst && st_q.cfg.coex == '0) |-> ##1 (gp_line_oe_o == $past(st_q.cfg.dir)))
		else $error("direction not applied");
endmodule

/* bench/pin_model.sv */
// outside circuitry of the general-purpose lines: drivers, sources and pulls
`timescale 1ns/10ps
module pin_model (
	input wire logic [9:0] oe_i,
	input wire logic [9:0] o_i,
	input wire logic [9:0] up_i,
	input wire logic [9:0] ext_en_i,
	input wire logic [9:0] ext_v_i,
	output logic [9:0] lvl_o
);
	// device drive wins, then an outside source, else the pull sets the level
	always_comb
	begin
		for (int i = 0; i < 10; i++)
			lvl_o[i] = oe_i[i] ? o_i[i] : ext_en_i[i] ? ext_v_i[i] : up_i[i];
	end
endmodule

/* bench/testbench.sv */
// self-checking bench of the pin bank: register port, pads, coexistence, reset
`timescale 1ns/10ps
module testbench;
	logic clock_i, sys_rst_i, module_rst_n_i, s_axi_awvalid, s_axi_awready;
	logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, coexist_peer_busy_o;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, an;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, br, ai, analog_capable_line_i;
	logic [1:0] analog_capable_line_o, analog_capable_line_oe_o;
	logic [9:0] gp_line_i, gp_line_o, gp_line_oe_o, gp_pull_up_weak_o, gp_pull_up_strong_o;
	logic [9:0] gp_pull_dn_weak_o, gp_pull_dn_strong_o, ext_en, ext_v, dir, dout, exl;
	logic [19:0] pl, eoo;
	logic [39:0] pv;
	logic [4:0] cx;
	int mismatches;
	int samples_checked;

	gpio_bank gpio_bank_i (.*);
	pin_model pin_model_i (
		.oe_i(gp_line_oe_o),
		.o_i(gp_line_o),
		.up_i(gp_pull_up_weak_o | gp_pull_up_strong_o),
		.ext_en_i(ext_en),
		.ext_v_i(ext_v),
		.lvl_o(gp_line_i)
	);

	// 200 MHz clock
	initial
	begin
		clock_i = 1'h0;
		forever #2.5 clock_i = ~clock_i;
	end

	task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
			mismatches++;
		end
	endtask

	// one write; the bench's own count is the only bound on waiting
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic ta, tw, tb;
		n = 0;
		tb = 1'h0;
		// start on a rising edge so a back-to-back call never re-drives in one step
		@(posedge clock_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!tb && n < 100)
		begin
			// sample mid-cycle: values then equal what the next rising edge sees
			@(negedge clock_i);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid;
			br = s_axi_bresp;
			@(posedge clock_i);
			if (ta)
				s_axi_awvalid <= 1'h0;
			if (tw)
				s_axi_wvalid <= 1'h0;
			n++;
		end
		s_axi_bready <= 1'h0;
		if (!tb)
			mismatches++;
	endtask

	task automatic rdr(input logic [7:0] a);
		int n;
		logic ta, tr;
		n = 0;
		tr = 1'h0;
		@(posedge clock_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		while (!tr && n < 100)
		begin
			@(negedge clock_i);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid;
			rd = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clock_i);
			if (ta)
				s_axi_arvalid <= 1'h0;
			n++;
		end
		s_axi_rready <= 1'h0;
		if (!tr)
			mismatches++;
	endtask

	// pad stage lags the register by a flop, so give it room
	task automatic settle();
		repeat (3) @(posedge clock_i);
		#1;
	endtask

	function automatic logic [39:0] pulls(input logic [19:0] p);
		logic [39:0] r;
		r = 40'h0;
		for (int i = 0; i < 10; i++)
		begin
			r[30 + i] = p[2 * i +: 2] == gpio_bank_pkg::PULL_WEAK_UP;
			r[20 + i] = p[2 * i +: 2] == gpio_bank_pkg::PULL_STRONG_UP;
			r[10 + i] = p[2 * i +: 2] == gpio_bank_pkg::PULL_WEAK_DN;
			r[i] = p[2 * i +: 2] == gpio_bank_pkg::PULL_STRONG_DN;
		end
		return r;
	endfunction

	function automatic logic [19:0] pad(input logic [9:0] d, v, input logic [4:0] c);
		logic [9:0] e;
		logic [9:0] o;
		e = d;
		o = v;
		e[2] = d[2] | c[0];
		o[2] = c[0] ? c[3] : v[2];
		e[3] = d[3] | c[1];
		o[3] = c[1] ? c[4] : v[3];
		e[4] = d[4] & ~c[2];
		return {e, o};
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// watchdog well past the expected run length
	initial
	begin
		repeat (50000) @(posedge clock_i);
		mismatches++;
		test_done();
	end

	// main sequence
	initial
	begin
		{sys_rst_i, module_rst_n_i} = 2'h3;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		{ext_en, ext_v, analog_capable_line_i} = 22'h0;
		void'($urandom(64));
		repeat (8) @(posedge clock_i);
		sys_rst_i <= 1'h0;
		settle();
		chk("oe", gp_line_oe_o, 10'h0);
		chk("pdw", gp_pull_dn_weak_o, 10'h3ff);
		chk("aoe", analog_capable_line_oe_o, 2'h0);
		rdr(gpio_bank_pkg::OFS_GP_DIR);
		chk("dir", rd, 32'h0);
		rdr(8'h20);
		chk("resp", rr, gpio_bank_pkg::RESP_SLVERR);
		chk("rdz", rd, gpio_bank_pkg::DECERR_DATA);
		wr(8'h20, 32'hffffffff);
		chk("bresp", br, gpio_bank_pkg::RESP_SLVERR);
		$display("test reset done");
		for (int k = 0; k < 24; k++)
		begin
			{dir, dout, pl, cx, an} = 49'({$urandom, $urandom});
			ext_en <= 10'($urandom);
			ext_v <= 10'($urandom);
			ai = (an[3:2] & an[1:0]) | (~an[1:0] & 2'($urandom));
			analog_capable_line_i <= ai;
			wr(gpio_bank_pkg::OFS_GP_DIR, {22'h0, dir});
			wr(gpio_bank_pkg::OFS_GP_OUT, {22'h0, dout});
			wr(gpio_bank_pkg::OFS_GP_PULL, {12'h0, pl});
			wr(gpio_bank_pkg::OFS_COEX, {27'h0, cx});
			wr(gpio_bank_pkg::OFS_AN_CTRL, {22'h0, an[3:2], 6'h0, an[1:0]});
			chk("bresp", br, gpio_bank_pkg::RESP_OKAY);
			settle();
			eoo = pad(dir, dout, cx);
			pv = pulls(pl);
			chk("oe", gp_line_oe_o, eoo[19:10]);
			chk("o", gp_line_o, eoo[9:0]);
			chk("pull", {gp_pull_up_weak_o, gp_pull_up_strong_o, gp_pull_dn_weak_o,
				gp_pull_dn_strong_o}, pv);
			exl = (eoo[19:10] & eoo[9:0]) | (~eoo[19:10] & ext_en & ext_v)
				| (~eoo[19:10] & ~ext_en & (pv[39:30] | pv[29:20]));
			chk("peer", coexist_peer_busy_o, cx[2] & exl[4]);
			chk("ao", {analog_capable_line_o, analog_capable_line_oe_o}, an);
			rdr(gpio_bank_pkg::OFS_GP_IN);
			chk("in", rd, exl);
			rdr(gpio_bank_pkg::OFS_AN_IN);
			chk("ain", rd, ai);
			rdr(gpio_bank_pkg::OFS_COEX_STAT);
			chk("cxs", rd, {31'h0, exl[4]});
		end
		$display("test random config done");
		// one byte lane only: upper pull fields must keep their old codes
		s_axi_wstrb <= 4'h1;
		wr(gpio_bank_pkg::OFS_GP_PULL, 32'hffffffff);
		s_axi_wstrb <= 4'hf;
		rdr(gpio_bank_pkg::OFS_GP_PULL);
		chk("strb", rd, {12'h0, pl[19:8], 8'hff});
		$display("test byte strobe done");
		// held past the internal settle time, scaled down from the real hold
		module_rst_n_i <= 1'h0;
		repeat (8) @(posedge clock_i);
		#1;
		chk("oe", gp_line_oe_o, 10'h0);
		chk("pdw", gp_pull_dn_weak_o, 10'h3ff);
		chk("aoe", analog_capable_line_oe_o, 2'h0);
		chk("pus", gp_pull_up_strong_o, 10'h0);
		@(posedge clock_i);
		module_rst_n_i <= 1'h1;
		settle();
		rdr(gpio_bank_pkg::OFS_GP_PULL);
		chk("pullrst", rd, {12'h0, gpio_bank_pkg::GP_PULL_RST});
		rdr(gpio_bank_pkg::OFS_COEX);
		chk("coex", rd, 32'h0);
		$display("test module reset done");
		test_done();
	end
endmodule
